// ===== rtl/epwm_consts.svh
// Register offsets, field positions, reset values and timing counts of the PWM output stage
`ifndef EPWM_CONSTS_SVH
`define EPWM_CONSTS_SVH

`define ADDR_RESTART_DEADBAND  12'h000
`define ADDR_SHUTDOWN_CTRL     12'h004
`define ADDR_IRQ_STATUS        12'h008
`define ADDR_IRQ_MASK          12'h00c
`define ADDR_MODE_CTRL         12'h010

`define RDB_RESTART_BIT        7
`define RDB_DELAY_MSB          6
`define RDB_RESET              8'h00

`define SDC_STATUS_BIT         7
`define SDC_BD_LSB             4
`define SDC_AC_LSB             2
`define SDC_SRC_MSB            2
`define SDC_RESET              8'h00

`define MODE_ENABLE_BIT        0
`define MODE_RESET             8'h00

`define IRQ_SHUTDOWN_BIT       0
`define IRQ_RESTART_BIT        1

`define INSTR_CYCLE_CLKS       4

`endif

// ===== rtl/epwm_pkg.sv
// Types of the PWM output stage
package epwm_pkg;
  typedef enum logic [1:0] {
    PAIR_LOW  = 2'h0,
    PAIR_HIGH = 2'h1,
    PAIR_HIZ  = 2'h2,
    PAIR_HIZ2 = 2'h3
  } pair_state_t;

  typedef enum logic [1:0] {
    SD_RUN     = 2'h0,
    SD_HELD    = 2'h1,
    SD_WAITPER = 2'h3
  } sd_state_t;
endpackage

// ===== rtl/epwm_output_stage.sv
// Half-bridge PWM output stage with dead band, auto-shutdown and APB registers
//
// Behaviour
// R1 - Output A modulated, output B its complement
// R2 - Delay each active edge by dead-band count
// R3 - Delay beyond duty keeps output inactive
// R4 - Count dead band in instruction cycles
// R5 - Three-bit field selects shutdown sources
// R6 - Low pin or high comparator shuts down
// R7 - Status reads one while shut down
// R8 - Event sets status until cleared
// R9 - Shutdown forces pins without clock edge
// R10 - Pairs AC and BD take configured states
// R11 - Shutdown level persists while present
// R12 - Status writes ignored while condition present
// R13 - Restart waits for next period start
// R14 - Writing one to status shuts down
// R15 - Auto restart clears software shutdown at once
// R16 - Auto restart clears status after event
// R17 - Without auto restart, software clears status
// R18 - Software makes pins outputs via direction
// R19 - Waiting output held inactive during count
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`include "epwm_consts.svh"

module epwm_output_stage #(
  parameter int DELAY_W = 7
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_duty_pwm,
  input  wire logic        i_period_start,
  input  wire logic        i_ext_int_pin,
  input  wire logic [1:0]  i_comparator_output,
  output logic             o_pwm_out_a,
  output logic             o_pwm_out_a_oe,
  output logic             o_pwm_out_b,
  output logic             o_pwm_out_b_oe,
  output logic             o_pwm_out_c,
  output logic             o_pwm_out_c_oe,
  output logic             o_pwm_out_d,
  output logic             o_pwm_out_d_oe,
  output logic             o_irq
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (DELAY_W != 7) begin : g_bad_width
    $error("DELAY_W must be 7");
  end

  if (`INSTR_CYCLE_CLKS != 4) begin : g_bad_prescale
    $error("Prescaler counter is two bits wide");
  end

  if (`SDC_BD_LSB != `SDC_AC_LSB + 2) begin : g_bad_pairs
    $error("Pair state fields must be adjacent");
  end

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_q;
  logic rst_b_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_b_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_b_q    <= rst_meta_q;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic [7:0] rdb_q;
  logic [7:0] sdc_q;
  logic [7:0] mode_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic       status_q;
  logic       wr_en;
  logic       hw_cond;
  logic       sw_status_wr;
  logic       sw_status_val;
  logic       auto_clear;
  logic       restart_ev;
  logic       running;

  // Zero wait states
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `ADDR_RESTART_DEADBAND) || (a == `ADDR_SHUTDOWN_CTRL) || (a == `ADDR_IRQ_STATUS) ||
               (a == `ADDR_IRQ_MASK) || (a == `ADDR_MODE_CTRL);
  endfunction

  // Unmapped offsets answer with an error and store nothing
  assign pslverr = psel && penable && !addr_hit(paddr);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // ****************************************
  // Register write
  // ****************************************
  // Restart enable and dead-band count
  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      rdb_q <= `RDB_RESET;
    end else if (wr_en && hit(paddr, `ADDR_RESTART_DEADBAND)) begin
      rdb_q <= pwdata[7:0];
    end
  end

  // Status bit is kept apart in status_q
  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      sdc_q <= `SDC_RESET;
    end else if (wr_en && hit(paddr, `ADDR_SHUTDOWN_CTRL)) begin
      sdc_q <= {1'b0, pwdata[6:0]};
    end
  end

  // Output enable
  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      mode_q <= `MODE_RESET;
    end else if (wr_en && hit(paddr, `ADDR_MODE_CTRL)) begin
      mode_q <= {7'h00, pwdata[0]};
    end
  end

  // Interrupt mask
  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      irq_mask_q <= 2'h0;
    end else if (wr_en && hit(paddr, `ADDR_IRQ_MASK)) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rd_word;

  always_comb begin
    case (paddr)
      `ADDR_RESTART_DEADBAND: rd_word = {24'h000000, rdb_q};
      `ADDR_SHUTDOWN_CTRL:    rd_word = {24'h000000, status_q, sdc_q[6:0]};  // [R7]
      `ADDR_IRQ_STATUS:       rd_word = {30'h0, irq_stat_q};
      `ADDR_IRQ_MASK:         rd_word = {30'h0, irq_mask_q};
      `ADDR_MODE_CTRL:        rd_word = {24'h000000, mode_q};
      default:                rd_word = 32'h0000_0000;
    endcase
  end

  // Taken in the setup cycle, held until the next read
  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

  // ****************************************
  // Shutdown control
  // ****************************************
  // Source select: bit0 pin, bit1 comparator 0, bit2 comparator 1
  assign hw_cond = (sdc_q[0] && !i_ext_int_pin) ||
                   (sdc_q[1] && i_comparator_output[0]) ||
                   (sdc_q[2] && i_comparator_output[1]);  // [R5] [R6]

  assign sw_status_wr  = wr_en && (paddr == `ADDR_SHUTDOWN_CTRL) && !hw_cond;  // [R12]
  assign sw_status_val = pwdata[`SDC_STATUS_BIT];
  assign auto_clear    = rdb_q[`RDB_RESTART_BIT] && !hw_cond;  // [R15] [R16]

  // Hardware set wins over any clear
  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      status_q <= 1'b0;
    end else if (hw_cond) begin
      status_q <= 1'b1;  // [R8] [R11]
    end else if (auto_clear) begin
      status_q <= 1'b0;  // [R15] [R16]
    end else if (sw_status_wr) begin
      status_q <= sw_status_val;  // [R14] [R17]
    end
  end

  // ****************************************
  // Shutdown sequencer
  // ****************************************
  epwm_pkg::sd_state_t sd_state_q;
  epwm_pkg::sd_state_t sd_state_d;

  // Outputs stay quiet after a shutdown until a period begins
  always_comb begin
    sd_state_d = sd_state_q;
    case (sd_state_q)
      epwm_pkg::SD_RUN: begin
        if (status_q || hw_cond) begin
          sd_state_d = epwm_pkg::SD_HELD;
        end
      end
      epwm_pkg::SD_HELD: begin
        if (!status_q && !hw_cond && i_period_start) begin
          sd_state_d = epwm_pkg::SD_RUN;  // [R13]
        end else if (!status_q && !hw_cond) begin
          sd_state_d = epwm_pkg::SD_WAITPER;
        end
      end
      epwm_pkg::SD_WAITPER: begin
        if (status_q || hw_cond) begin
          sd_state_d = epwm_pkg::SD_HELD;
        end else if (i_period_start) begin
          sd_state_d = epwm_pkg::SD_RUN;  // [R13]
        end
      end
      default: sd_state_d = epwm_pkg::SD_HELD;
    endcase
  end

  // Held until the first period start after reset
  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      sd_state_q <= epwm_pkg::SD_WAITPER;
    end else begin
      sd_state_q <= sd_state_d;
    end
  end

  assign running    = (sd_state_q == epwm_pkg::SD_RUN);
  assign restart_ev = !running && !status_q && !hw_cond && i_period_start;

  // ****************************************
  // Interrupts
  // ****************************************
  // Set wins over a clear in the same cycle

  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q[`IRQ_SHUTDOWN_BIT] <= (hw_cond && !status_q) ||
        (irq_stat_q[`IRQ_SHUTDOWN_BIT] && !(wr_en && paddr == `ADDR_IRQ_STATUS && pwdata[0]));
      irq_stat_q[`IRQ_RESTART_BIT]  <= restart_ev ||
        (irq_stat_q[`IRQ_RESTART_BIT] && !(wr_en && paddr == `ADDR_IRQ_STATUS && pwdata[1]));
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // ****************************************
  // Dead band
  // ****************************************
  logic [1:0]         prescale_q;
  logic               instr_tick;
  logic               duty_q;
  logic [DELAY_W-1:0] cnt_a_q;
  logic [DELAY_W-1:0] cnt_b_q;
  logic               act_a_q;
  logic               act_b_q;
  logic [DELAY_W-1:0] delay;

  assign delay = rdb_q[`RDB_DELAY_MSB:0];

  // ****************************************
  // Instruction-cycle prescaler
  // ****************************************

  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      prescale_q <= 2'h0;
    end else begin
      prescale_q <= (prescale_q == 2'(`INSTR_CYCLE_CLKS - 1)) ? 2'h0 : prescale_q + 2'h1;  // [R4]
    end
  end

  assign instr_tick = (prescale_q == 2'(`INSTR_CYCLE_CLKS - 1));

  // ****************************************
  // Dead-band counters
  // ****************************************

  always_ff @(posedge i_ref_clk or negedge rst_b_q) begin
    if (!rst_b_q) begin
      duty_q  <= 1'b0;
      cnt_a_q <= '0;
      cnt_b_q <= '0;
      act_a_q <= 1'b0;
      act_b_q <= 1'b0;
    end else begin
      duty_q <= i_duty_pwm;
      if (i_duty_pwm != duty_q) begin
        cnt_a_q <= delay;
        cnt_b_q <= delay;
        act_a_q <= 1'b0;  // [R19]
        act_b_q <= 1'b0;  // [R19]
      end else if (instr_tick) begin
        // A level that ends before the count expires never activates
        if (i_duty_pwm && !act_a_q) begin
          if (cnt_a_q == '0) act_a_q <= 1'b1;  // [R2] [R3]
          else cnt_a_q <= cnt_a_q - 1'b1;
        end
        if (!i_duty_pwm && !act_b_q) begin
          if (cnt_b_q == '0) act_b_q <= 1'b1;  // [R2] [R3]
          else cnt_b_q <= cnt_b_q - 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  logic       sd_now;
  logic       enable;
  logic       pwm_a;
  logic       pwm_b;
  logic [3:0] pwm_lvl;
  logic [3:0] pwm_oe;
  wire  [3:0] pin_lvl;
  wire  [3:0] pin_oe;

  assign sd_now  = hw_cond || status_q || !running;  // [R9]
  assign enable  = mode_q[`MODE_ENABLE_BIT];
  assign pwm_a   = i_duty_pwm && act_a_q;  // [R1]
  assign pwm_b   = !i_duty_pwm && act_b_q;  // [R1]
  // Pins in order A, B, C, D; C and D idle in half-bridge operation
  assign pwm_lvl = {1'b0, 1'b0, pwm_b, pwm_a};
  assign pwm_oe  = {1'b0, 1'b0, enable, enable};

  function automatic logic pair_level(input logic [1:0] s);
    pair_level = (s == 2'(epwm_pkg::PAIR_HIGH));
  endfunction

  function automatic logic pair_drive(input logic [1:0] s);
    pair_drive = (s == 2'(epwm_pkg::PAIR_LOW)) || (s == 2'(epwm_pkg::PAIR_HIGH));
  endfunction

  // A and C follow the AC pair state, B and D the BD pair state
  for (genvar p = 0; p < 4; p++) begin : g_pin
    logic [1:0] sd_cfg;

    assign sd_cfg     = (p % 2 == 0) ? sdc_q[`SDC_AC_LSB +: 2] : sdc_q[`SDC_BD_LSB +: 2];
    assign pin_lvl[p] = (sd_now && enable) ? pair_level(sd_cfg) : pwm_lvl[p];  // [R10]
    assign pin_oe[p]  = (sd_now && enable) ? pair_drive(sd_cfg) : pwm_oe[p];  // [R10]
  end

  assign o_pwm_out_a    = pin_lvl[0];
  assign o_pwm_out_b    = pin_lvl[1];
  assign o_pwm_out_c    = pin_lvl[2];
  assign o_pwm_out_d    = pin_lvl[3];
  assign o_pwm_out_a_oe = pin_oe[0];
  assign o_pwm_out_b_oe = pin_oe[1];
  assign o_pwm_out_c_oe = pin_oe[2];
  assign o_pwm_out_d_oe = pin_oe[3];

endmodule

// ===== testbench/epwm_output_stage_assertions.sv
// Port assertions of the PWM output stage
module epwm_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        i_duty_pwm,
  input wire logic        i_ext_int_pin,
  input wire logic [1:0]  i_comparator_output,
  input wire logic        o_pwm_out_a,
  input wire logic        o_pwm_out_a_oe,
  input wire logic        o_pwm_out_b,
  input wire logic        o_pwm_out_b_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  wire a_on = o_pwm_out_a && o_pwm_out_a_oe;
  wire b_on = o_pwm_out_b && o_pwm_out_b_oe;
  AST_A_DUTY: assert property (a_on |-> i_duty_pwm) else $error("A active with duty low");
  AST_B_DUTY: assert property (b_on |-> !i_duty_pwm) else $error("B active with duty high");
  AST_A_DEAD: assert property ($rose(i_duty_pwm) |-> !a_on [*8] ##1 !a_on [*3]) else $error("A early");
  AST_B_DEAD: assert property ($fell(i_duty_pwm) |-> !b_on [*8] ##1 !b_on [*3]) else $error("B early");
  AST_NO_BOTH: assert property (!(a_on && b_on)) else $error("A and B both active");
  AST_PIN_OFF: assert property (!i_ext_int_pin |-> !a_on) else $error("A active on pin event");
  AST_CMP_OFF: assert property (i_comparator_output[0] |-> !a_on) else $error("A on comparator");
  AST_STATUS: assert property (!i_ext_int_pin [*2] ##0 (psel && !penable && !pwrite && paddr == 12'h004)
    |=> prdata[7]) else $error("Status not set");
  AST_HOLD: assert property ($rose(i_ext_int_pin) |-> !a_on [*8]) else $error("Early resume");
  cover property ($rose(a_on));
  cover property ($fell(i_ext_int_pin));
  cover property ($rose(i_comparator_output[0]));
endmodule

// ===== testbench/epwm_partner.sv
// Pads of the switch drivers and the shutdown sources
module epwm_partner (
  input  wire logic       i_a,
  input  wire logic       i_a_oe,
  input  wire logic       i_b,
  input  wire logic       i_b_oe,
  input  wire logic       i_trip,
  input  wire logic [1:0] i_cmp,
  output logic            o_pad_a,
  output logic            o_pad_b,
  output logic            o_int_pin,
  output logic [1:0]      o_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Gate pull-downs hold undriven pads low
  assign o_pad_a   = i_a_oe ? i_a : 1'b0;
  assign o_pad_b   = i_b_oe ? i_b : 1'b0;
  assign o_int_pin = !i_trip;
  assign o_cmp     = i_cmp;
endmodule

// ===== testbench/tb.sv
// Self-checking bench of the PWM output stage
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, psel, penable, pwrite, duty, per, trip, run;
  logic        pready, pslverr, a, a_oe, b, b_oe, irq, pad_a, pad_b, pin;
  logic        c, c_oe, d, d_oe, err;
  logic [1:0]  cmp, cmp_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count, n_checks, cyc, ph;
  epwm_output_stage dut (.i_ref_clk(clk), .i_rst_b(rst_b), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .i_duty_pwm(duty), .i_period_start(per), .i_ext_int_pin(pin), .i_comparator_output(cmp_pin),
    .o_pwm_out_a(a), .o_pwm_out_a_oe(a_oe), .o_pwm_out_b(b), .o_pwm_out_b_oe(b_oe), .o_pwm_out_c(c),
    .o_pwm_out_c_oe(c_oe), .o_pwm_out_d(d), .o_pwm_out_d_oe(d_oe), .o_irq(irq));
  epwm_partner far (.i_a(a), .i_a_oe(a_oe), .i_b(b), .i_b_oe(b_oe), .i_trip(trip), .i_cmp(cmp),
    .o_pad_a(pad_a), .o_pad_b(pad_b), .o_int_pin(pin), .o_cmp(cmp_pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Timebase: 40-cycle period, 20 cycles duty
  always @(posedge clk) begin
    cyc  <= cyc + 1;
    ph   <= run ? (ph + 1) % 40 : 0;
    per  <= run && ph == 0;
    duty <= run && ph < 20;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    apb(1'b0, 12'h000, 0);
    chk(rd, 0);
    apb(1'b0, 12'h004, 0);
    chk(rd, 0);
    chk(err, 0);
    apb(1'b0, 12'h01c, 0);
    chk(rd, 0);
    chk(err, 1);
  endtask
  task automatic t_dead();
    int n;
    apb(1'b1, 12'h000, 3);
    run <= 1'b1;
    repeat (45) @(posedge clk);
    while (duty !== 1'b0) @(posedge clk);
    while (duty !== 1'b1) @(posedge clk);
    for (n = 0; pad_a !== 1'b1 && n < 40; n++) @(posedge clk);
    chk(n >= 11 && n <= 17, 1);
    chk(pad_b, 0);
    while (duty !== 1'b0) @(posedge clk);
    for (n = 0; pad_b !== 1'b1 && n < 40; n++) @(posedge clk);
    chk(n >= 11 && n <= 17, 1);
  endtask
  task automatic t_long();
    int n;
    apb(1'b1, 12'h000, 32'h1e);
    while (duty !== 1'b0) @(posedge clk);
    n = 0;
    repeat (80) begin
      @(posedge clk);
      if (pad_a !== 1'b0 || pad_b !== 1'b0) n++;
    end
    chk(n, 0);
  endtask
  task automatic t_pin();
    apb(1'b1, 12'h000, 3);
    repeat (60) @(posedge clk);
    trip <= 1'b1;
    #1;
    chk({a_oe, b_oe, pad_b}, 3'b010);
    chk({c_oe, d_oe, d}, 3'b010);
    apb(1'b0, 12'h004, 0);
    chk({irq, rd[7]}, 3);
    apb(1'b1, 12'h004, 32'h0b);
    apb(1'b1, 12'h008, 1);
    apb(1'b0, 12'h004, 0);
    chk({irq, rd[7]}, 1);
    trip <= 1'b0;
    repeat (60) @(posedge clk);
    apb(1'b0, 12'h004, 0);
    chk({a_oe, rd[7]}, 1);
    apb(1'b1, 12'h004, 32'h0b);
    @(posedge clk);
    while (per !== 1'b1) begin
      chk(a_oe, 0);
      @(posedge clk);
    end
    @(posedge clk);
    chk(a_oe, 1);
  endtask
  task automatic t_cmp();
    apb(1'b1, 12'h00c, 0);
    apb(1'b1, 12'h000, 32'h83);
    cmp <= 2'b10;
    repeat (2) @(posedge clk);
    chk(a_oe, 1);
    chk({c_oe, d_oe}, 0);
    cmp <= 2'b01;
    apb(1'b0, 12'h004, 0);
    chk({irq, a_oe, rd[7]}, 1);
    cmp <= 2'b00;
    apb(1'b0, 12'h004, 0);
    chk(rd[7], 0);
    apb(1'b1, 12'h004, 32'h8b);
    apb(1'b0, 12'h004, 0);
    chk(rd[7], 0);
    apb(1'b1, 12'h000, 3);
    apb(1'b1, 12'h004, 32'h8b);
    #1;
    chk(a_oe, 0);
    apb(1'b0, 12'h004, 0);
    chk(rd[7], 1);
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, run, trip, cmp, paddr, pwdata, duty, per} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    apb(1'b1, 12'h010, 1);
    apb(1'b1, 12'h004, 32'h0b);
    apb(1'b1, 12'h00c, 1);
    t_dead();
    t_long();
    t_pin();
    t_cmp();
    final_report();
  end
endmodule
bind epwm_output_stage epwm_checker chk_i (.i_ref_clk, .i_rst_b, .psel, .penable, .pwrite, .paddr, .prdata,
  .i_duty_pwm, .i_ext_int_pin, .i_comparator_output, .o_pwm_out_a, .o_pwm_out_a_oe, .o_pwm_out_b, .o_pwm_out_b_oe);
